//--- include/acq_pkg.sv
package acq_pkg;

  // Data and port widths.
  localparam int DATA_W = 8;
  localparam int PORT_W = 8;

  // Write ports.
  localparam logic [7:0] WP_MEM_CTL   = 8'h0c;
  localparam logic [7:0] WP_WR_CTL    = 8'h08;
  localparam logic [7:0] WP_TRIG_CTL  = 8'h0b;
  localparam logic [7:0] WP_WR_DATA   = 8'h07;
  localparam logic [7:0] WP_RES_CTL   = 8'h0d;
  localparam logic [7:0] WP_STEP      = 8'h04;
  localparam logic [7:0] WP_CNT_LOAD  = 8'h05;
  localparam logic [7:0] WP_CLEAR     = 8'h0a;

  // Read ports.
  localparam logic [7:0] RP_POD_STAT  = 8'h01;
  localparam logic [7:0] RP_MOS_STAT  = 8'h02;
  localparam logic [7:0] RP_CNT       = 8'h03;
  localparam logic [7:0] RP_PHASE     = 8'h04;

  // Control register fields.
  localparam int MC_LOAD_INH0  = 0;
  localparam int MC_LOAD_INH1  = 4;
  localparam int MC_ACCESS_EN  = 6;
  localparam int MC_STEP_EN    = 7;
  localparam int WC_ECHO       = 3;
  localparam int TC_ECHO       = 4;
  localparam int WD_ECHO       = 2;
  localparam int RC_ECHO       = 7;

  // Status port fields.
  localparam int POD_ACCESS    = 1;
  localparam int POD_WC        = 3;
  localparam int POD_WD        = 7;
  localparam int MOS_OVF       = 0;
  localparam int MOS_TC        = 1;
  localparam int MOS_RC        = 5;

  // Reset values and the counter top value.
  localparam logic [7:0] CTL_RST   = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [7:0] CNT_RST   = 8'h00;
  localparam logic [7:0] CNT_TOP   = 8'hff;

endpackage : acq_pkg

//--- rtl/acq_ring.sv
`timescale 1ns/1ns
// Loadable clock-phase ring; bit 7 carries round into bit 0.
module acq_ring #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Control.
  input  wire logic         load,
  input  wire logic         adv,
  input  wire logic [W-1:0] din,
  // Phase outputs.
  output logic      [W-1:0] q
);

  // The reset value is a byte constant, so only a byte-wide ring is served.
  if (W != acq_pkg::DATA_W) begin : g_chk
    $error("acq_ring serves only a byte-wide ring");
  end

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  assign q_nxt = load ? din : (adv ? {q_r[W-2:0], q_r[W-1]} : q_r);
  assign q     = q_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q_r <= acq_pkg::PHASE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule : acq_ring

//--- rtl/acq_cnt.sv
`timescale 1ns/1ns
// Memory address counter with load priority and a wrap pulse.
module acq_cnt #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Control.
  input  wire logic         load_n,
  input  wire logic         inc,
  input  wire logic [W-1:0] din,
  // Count and wrap.
  output logic      [W-1:0] q,
  output logic              wrap
);

  // The reset value is a byte constant, so only a byte-wide counter is served.
  if (W != acq_pkg::DATA_W) begin : g_chk
    $error("acq_cnt serves only a byte-wide counter");
  end

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  assign wrap  = inc && load_n && (q_r == {W{1'b1}});
  assign q_nxt = !load_n ? din : (inc ? q_r + 1'b1 : q_r);
  assign q     = q_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q_r <= acq_pkg::CNT_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule : acq_cnt

//--- rtl/acq_regs.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module acq_regs #(
  parameter int DW = 8
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Host I/O port.
  input  wire logic [7:0]    io_addr,
  input  wire logic [DW-1:0] io_wdata,
  input  wire logic          io_wr,
  input  wire logic          io_rd,
  output logic      [DW-1:0] io_rdata,
  output logic               io_rdata_oe,
  // Control settings to the high-speed logic.
  output logic      [DW-1:0] memory_control_reg,
  output logic      [DW-1:0] write_control_reg,
  output logic      [DW-1:0] trigger_control_reg,
  output logic      [DW-1:0] write_data_reg,
  output logic      [DW-1:0] resolution_control_reg,
  // Clock phases and address.
  output logic      [DW-1:0] phase_clocks,
  output logic               phase_clock_0,
  output logic      [DW-1:0] address_counter,
  output logic               address_counter_overflow,
  // Expander clock.
  output logic               exp_addr_step
);

  if (DW != acq_pkg::DATA_W) begin : g_chk
    $error("acq_regs serves only a byte-wide data bus");
  end

  function automatic logic port_hit(input logic [7:0] a,
                                    input logic [7:0] p);
    port_hit = (a == p);
  endfunction : port_hit

  // Write decode.
  logic wr_mem;
  logic wr_wc;
  logic wr_tc;
  logic wr_wd;
  logic wr_rc;
  logic wr_step;
  logic wr_clear;
  logic address_counter_load_n;
  logic [DW-1:0] internal_data_bus;

  assign internal_data_bus = io_wdata;
  assign wr_mem   = io_wr && port_hit(io_addr, acq_pkg::WP_MEM_CTL);
  assign wr_wc    = io_wr && port_hit(io_addr, acq_pkg::WP_WR_CTL);
  assign wr_tc    = io_wr && port_hit(io_addr, acq_pkg::WP_TRIG_CTL);
  assign wr_wd    = io_wr && port_hit(io_addr, acq_pkg::WP_WR_DATA);
  assign wr_rc    = io_wr && port_hit(io_addr, acq_pkg::WP_RES_CTL);
  assign wr_step  = io_wr && port_hit(io_addr, acq_pkg::WP_STEP);
  assign wr_clear = io_wr && port_hit(io_addr, acq_pkg::WP_CLEAR);
  assign address_counter_load_n =
    !(io_wr && port_hit(io_addr, acq_pkg::WP_CNT_LOAD));

  // Control registers.
  logic [DW-1:0] mem_r;
  logic [DW-1:0] wc_r;
  logic [DW-1:0] tc_r;
  logic [DW-1:0] wd_r;
  logic [DW-1:0] rc_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_r <= acq_pkg::CTL_RST;
      wc_r  <= acq_pkg::CTL_RST;
      tc_r  <= acq_pkg::CTL_RST;
      wd_r  <= acq_pkg::CTL_RST;
      rc_r  <= acq_pkg::CTL_RST;
    end else begin
      if (wr_mem) mem_r <= io_wdata;
      if (wr_wc)  wc_r  <= io_wdata;
      if (wr_tc)  tc_r  <= io_wdata;
      if (wr_wd)  wd_r  <= io_wdata;
      if (wr_rc)  rc_r  <= io_wdata;
    end
  end

  assign memory_control_reg     = mem_r;
  assign write_control_reg      = wc_r;
  assign trigger_control_reg    = tc_r;
  assign write_data_reg         = wd_r;
  assign resolution_control_reg = rc_r;

  // Clock generation: free-running unless single stepping is enabled.
  logic access_en;
  logic step_mode;
  logic ring_load_ok;
  logic phase_adv;
  logic phase_load;
  logic cnt_inc;
  logic cnt_wrap;
  logic [DW-1:0] phase_q;
  logic [DW-1:0] cnt_q;

  assign access_en    = mem_r[acq_pkg::MC_ACCESS_EN];
  assign step_mode    = mem_r[acq_pkg::MC_STEP_EN];
  assign ring_load_ok = !mem_r[acq_pkg::MC_LOAD_INH0] &&
                        !mem_r[acq_pkg::MC_LOAD_INH1];
  assign phase_adv    = step_mode ? wr_step : 1'b1;
  assign phase_load   = step_mode && wr_step && ring_load_ok;
  // The counter advances on each phase-0 tick of the ring.
  assign cnt_inc      = phase_adv && phase_q[0];

  acq_ring #(
    .W    (DW)
  ) u_ring (
    .clk  (clk),
    .rst_b(rst_b),
    .load (phase_load),
    .adv  (phase_adv),
    .din  (internal_data_bus),
    .q    (phase_q)
  );

  acq_cnt #(
    .W     (DW)
  ) u_cnt (
    .clk   (clk),
    .rst_b (rst_b),
    .load_n(address_counter_load_n),
    .inc   (cnt_inc),
    .din   (internal_data_bus),
    .q     (cnt_q),
    .wrap  (cnt_wrap)
  );

  assign phase_clocks    = phase_q;
  assign phase_clock_0   = phase_q[0];
  assign address_counter = cnt_q;

  // Overflow flag: a wrap in the clearing cycle still sets it.
  logic ovf_r;
  logic ovf_nxt;
  logic step_r;

  assign ovf_nxt = cnt_wrap ? 1'b1 : (wr_clear ? 1'b0 : ovf_r);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ovf_r  <= 1'b0;
      step_r <= 1'b0;
    end else begin
      ovf_r  <= ovf_nxt;
      step_r <= cnt_inc;
    end
  end

  assign address_counter_overflow = ovf_r;
  assign exp_addr_step            = step_r;

  // Read path.
  logic [DW-1:0] pod_stat;
  logic [DW-1:0] mos_stat;
  logic [DW-1:0] rd_mux;
  logic          rd_hit;
  logic          rd_pod;
  logic          rd_mos;
  logic          rd_cnt;
  logic          rd_ph;
  logic [DW-1:0] rdata_r;
  logic          rdata_oe_r;

  always_comb begin
    pod_stat = '0;
    pod_stat[acq_pkg::POD_ACCESS] = mem_r[acq_pkg::MC_ACCESS_EN];
    pod_stat[acq_pkg::POD_WC]     = wc_r[acq_pkg::WC_ECHO];
    pod_stat[acq_pkg::POD_WD]     = wd_r[acq_pkg::WD_ECHO];
  end

  always_comb begin
    mos_stat = '0;
    mos_stat[acq_pkg::MOS_OVF] = ovf_r;
    mos_stat[acq_pkg::MOS_TC]  = tc_r[acq_pkg::TC_ECHO];
    mos_stat[acq_pkg::MOS_RC]  = rc_r[acq_pkg::RC_ECHO];
  end

  assign rd_pod = io_rd && port_hit(io_addr, acq_pkg::RP_POD_STAT);
  assign rd_mos = io_rd && port_hit(io_addr, acq_pkg::RP_MOS_STAT);
  assign rd_cnt = io_rd && port_hit(io_addr, acq_pkg::RP_CNT);
  assign rd_ph  = io_rd && port_hit(io_addr, acq_pkg::RP_PHASE);
  // Acquisition readback ports stay dark while access is disabled.
  assign rd_hit = rd_pod || rd_mos ||
                  ((rd_cnt || rd_ph) && access_en);
  assign rd_mux = rd_pod ? pod_stat :
                  rd_mos ? mos_stat :
                  (rd_cnt && access_en) ? cnt_q :
                  (rd_ph && access_en) ? phase_q :
                  '0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r    <= '0;
      rdata_oe_r <= 1'b0;
    end else begin
      rdata_r    <= rd_mux;
      rdata_oe_r <= rd_hit;
    end
  end

  assign io_rdata    = rdata_r;
  assign io_rdata_oe = rdata_oe_r;

  // Checks.
  a_reg_capture: assert property (@(posedge clk) disable iff (!rst_b)
    wr_wc |=> (write_control_reg == $past(io_wdata)))
    else $error("write control register missed a write");

  a_pod_echo: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_mem ##1 (rd_pod && !wr_mem)) |=>
      (io_rdata[acq_pkg::POD_ACCESS] ==
       $past(memory_control_reg[acq_pkg::MC_ACCESS_EN])))
    else $error("pod status lost memory access enable");

  a_mos_echo: assert property (@(posedge clk) disable iff (!rst_b)
    rd_mos |=> (io_rdata[acq_pkg::MOS_TC] ==
                $past(tc_r[acq_pkg::TC_ECHO])) &&
               (io_rdata[acq_pkg::MOS_RC] ==
                $past(rc_r[acq_pkg::RC_ECHO])))
    else $error("status port echo bits wrong");

  a_access_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (io_rd && !access_en && !rd_pod && !rd_mos) |=> !io_rdata_oe)
    else $error("readback driven with access disabled");

  a_ring_rotate: assert property (@(posedge clk) disable iff (!rst_b)
    (phase_adv && !phase_load) |=>
      (phase_clocks == {$past(phase_clocks[DW-2:0]),
                        $past(phase_clocks[DW-1])}))
    else $error("phase ring did not rotate");

  a_ring_load: assert property (@(posedge clk) disable iff (!rst_b)
    phase_load |=> (phase_clocks == $past(io_wdata)))
    else $error("phase ring did not load");

  a_cnt_load: assert property (@(posedge clk) disable iff (!rst_b)
    !address_counter_load_n |=> (address_counter == $past(io_wdata)))
    else $error("address counter did not load");

  a_cnt_inc: assert property (@(posedge clk) disable iff (!rst_b)
    (cnt_inc && address_counter_load_n) |=>
      (address_counter == $past(address_counter) + 8'h01))
    else $error("address counter did not step");

  a_ovf_set: assert property (@(posedge clk) disable iff (!rst_b)
    (cnt_inc && address_counter_load_n && address_counter == 8'hff)
      |=> address_counter_overflow ##1
          (address_counter_overflow || $past(wr_clear)))
    else $error("overflow flag not raised on wrap");

  a_rd_window: assert property (@(posedge clk) disable iff (!rst_b)
    !io_rd |=> !io_rdata_oe)
    else $error("read data driven outside a read");

  a_exp_step: assert property (@(posedge clk) disable iff (!rst_b)
    cnt_inc |=> exp_addr_step)
    else $error("expander step not forwarded");

  a_mem_capture: assert property (@(posedge clk) disable iff (!rst_b)
    wr_mem |=> (memory_control_reg == $past(io_wdata)))
    else $error("memory control register missed a write");

  a_tc_capture: assert property (@(posedge clk) disable iff (!rst_b)
    wr_tc |=> (trigger_control_reg == $past(io_wdata)))
    else $error("trigger control register missed a write");

  a_wd_capture: assert property (@(posedge clk) disable iff (!rst_b)
    wr_wd |=> (write_data_reg == $past(io_wdata)))
    else $error("write data register missed a write");

  a_rc_capture: assert property (@(posedge clk) disable iff (!rst_b)
    wr_rc |=> (resolution_control_reg == $past(io_wdata)))
    else $error("resolution register missed a write");

  a_reg_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !wr_wc |=> $stable(write_control_reg))
    else $error("write control register changed without a write");

  a_port_select: assert property (@(posedge clk) disable iff (!rst_b)
    (io_wr && !wr_mem) |=> $stable(memory_control_reg))
    else $error("memory control register took a foreign write");

  a_pod_bits: assert property (@(posedge clk) disable iff (!rst_b)
    rd_pod |=> io_rdata_oe &&
      (io_rdata[acq_pkg::POD_WC] == $past(wc_r[acq_pkg::WC_ECHO])) &&
      (io_rdata[acq_pkg::POD_WD] == $past(wd_r[acq_pkg::WD_ECHO])))
    else $error("pod status echo bits wrong");

  a_cnt_read: assert property (@(posedge clk) disable iff (!rst_b)
    (rd_cnt && access_en) |=>
      (io_rdata_oe && (io_rdata == $past(address_counter))))
    else $error("counter readback wrong");

  a_ph_read: assert property (@(posedge clk) disable iff (!rst_b)
    (rd_ph && access_en) |=>
      (io_rdata_oe && (io_rdata == $past(phase_clocks))))
    else $error("phase readback wrong");

  a_cnt_clock: assert property (@(posedge clk) disable iff (!rst_b)
    (!cnt_inc && address_counter_load_n) |=> $stable(address_counter))
    else $error("address counter moved without a phase-0 clock");

  a_step_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (step_mode && !wr_step) |=> $stable(phase_clocks))
    else $error("phase ring moved without a single step");

  a_ovf_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_clear && !cnt_wrap) |=> !address_counter_overflow)
    else $error("overflow flag not cleared");

  a_exp_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !cnt_inc |=> !exp_addr_step)
    else $error("expander step without a counter step");

endmodule : acq_regs

//--- tb/acq_host_model.sv
`timescale 1ns/1ns
// Host controller side of the I/O port; lines it releases show the
// inverse of their last value.
module acq_host_model (
  // Clock.
  input  wire logic       clk,
  // Host I/O port.
  output logic      [7:0] io_addr,
  output logic      [7:0] io_wdata,
  output logic            io_wr,
  output logic            io_rd
);
  initial begin
    io_addr  = 8'h00;
    io_wdata = 8'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    io_rd    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= ~io_wdata;
    io_wr    <= 1'b0;
    io_rd    <= 1'b1;
  endtask : rd

  task automatic idle();
    @(posedge clk);
    io_addr  <= ~io_addr;
    io_wdata <= ~io_wdata;
    io_wr    <= 1'b0;
    io_rd    <= 1'b0;
  endtask : idle
endmodule : acq_host_model

//--- tb/acq_regs_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module acq_regs_tb;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] io_addr, io_wdata, io_rdata;
  logic       io_wr, io_rd, io_rdata_oe, exp_addr_step;
  logic [7:0] mem, wc, tc, wd, rc, v, d, ph, cn;
  logic [7:0] mc_o, wc_o, tc_o, wd_o, rc_o, ph_o, cn_o;
  logic       ph0_o, ovf_o;
  logic       ovf, rd_seen = 1'b0;
  logic [65:0] e;
  logic [65:0] exp_q[$];
  logic [31:0] rs = 32'd93122;
  int err_total = 0, n_compared = 0, cyc = 0, n_step = 0, s0;
  logic [7:0] wp [5] = '{8'h0c, 8'h08, 8'h0b, 8'h07, 8'h0d};
  int bp [5] = '{6, 3, 4, 2, 7};

  initial forever #20 clk = ~clk;

  acq_host_model i_host (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd));
  acq_regs #(.DW(8)) i_dut (.clk(clk), .rst_b(rst_b), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .io_rdata_oe(io_rdata_oe), .memory_control_reg(mc_o),
    .write_control_reg(wc_o), .trigger_control_reg(tc_o),
    .write_data_reg(wd_o), .resolution_control_reg(rc_o),
    .phase_clocks(ph_o), .phase_clock_0(ph0_o),
    .address_counter(cn_o), .address_counter_overflow(ovf_o),
    .exp_addr_step(exp_addr_step));

  function automatic logic [7:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : xs

  function automatic logic [8:0] pod();
    return {1'b1, wd[2], 3'b000, wc[3], 1'b0, mem[6], 1'b0};
  endfunction : pod

  function automatic logic [8:0] mos();
    return {1'b1, 2'b00, rc[7], 3'b000, tc[4], ovf};
  endfunction : mos

  task automatic w(input logic [7:0] a, input logic [7:0] x);
    case (a)
      acq_pkg::WP_MEM_CTL:  mem = x;
      acq_pkg::WP_WR_CTL:   wc  = x;
      acq_pkg::WP_TRIG_CTL: tc  = x;
      acq_pkg::WP_WR_DATA:  wd  = x;
      acq_pkg::WP_RES_CTL:  rc  = x;
      acq_pkg::WP_CLEAR:    ovf = 1'b0;
      acq_pkg::WP_CNT_LOAD: cn  = x;
      acq_pkg::WP_STEP: if (mem[7]) begin
        if (ph[0]) begin
          ovf = ovf | (cn == 8'hff);
          cn  = cn + 8'h01;
        end
        ph = (!mem[0] && !mem[4]) ? x : {ph[6:0], ph[7]};
      end
      default: ;
    endcase
    i_host.wr(a, x);
  endtask : w

  task automatic r(input logic [7:0] a, input logic [8:0] x);
    exp_q.push_back({x, mem, wc, tc, wd, rc, ph, cn, ovf});
    i_host.rd(a);
  endtask : r

  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Read results land exactly one cycle after the read strobe.
  always @(posedge clk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      `CHK({io_rdata_oe, io_rdata}, e[65:57])
      `CHK({mc_o, wc_o, tc_o, wd_o, rc_o}, e[56:17])
      `CHK(ph_o, e[16:9])
      `CHK(ph0_o, e[9])
      `CHK(cn_o, e[8:1])
      `CHK(ovf_o, e[0])
    end else if (rst_b) begin
      `CHK(io_rdata_oe, 1'b0)
    end
    rd_seen <= io_rd & rst_b;
    if (exp_addr_step === 1'b1) n_step++;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    {mem, wc, tc, wd, rc, ph, cn, ovf} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    i_host.idle();
    r(acq_pkg::RP_POD_STAT, pod());
    r(acq_pkg::RP_MOS_STAT, mos());
    for (int p = 1; p >= 0; p--) begin
      for (int i = 0; i < 5; i++) begin
        d = xs();
        d[bp[i]] = p[0];
        if (i == 0) d[7] = 1'b1;
        w(wp[i], d);
        r(acq_pkg::RP_POD_STAT, pod());
        r(acq_pkg::RP_MOS_STAT, mos());
      end
    end
    r(acq_pkg::RP_CNT, 9'h000);
    r(acq_pkg::RP_PHASE, 9'h000);
    w(8'h3f, xs());
    r(acq_pkg::RP_POD_STAT, pod());
    r(8'h09, 9'h000);
    w(acq_pkg::WP_MEM_CTL, 8'hc0);
    for (int i = 0; i < 9; i++) begin
      v = (i < 8) ? (8'h80 >> i) : 8'h00;
      w(acq_pkg::WP_STEP, v);
      r(acq_pkg::RP_PHASE, {1'b1, v});
    end
    w(acq_pkg::WP_STEP, 8'h80);
    w(acq_pkg::WP_MEM_CTL, 8'hc1);
    w(acq_pkg::WP_STEP, 8'h5a);
    r(acq_pkg::RP_PHASE, 9'h101);
    for (int i = 0; i < 9; i++) begin
      v = (i < 8) ? (8'h80 >> i) : 8'h00;
      w(acq_pkg::WP_CNT_LOAD, v);
      r(acq_pkg::RP_CNT, {1'b1, v});
    end
    w(acq_pkg::WP_MEM_CTL, 8'hc0);
    w(acq_pkg::WP_CNT_LOAD, 8'h00);
    s0 = n_step;
    for (int k = 1; k < 256; k++) begin
      w(acq_pkg::WP_STEP, 8'h01);
      i_host.idle();
      r(acq_pkg::RP_CNT, {1'b1, k[7:0]});
    end
    w(acq_pkg::WP_CLEAR, xs());
    r(acq_pkg::RP_MOS_STAT, mos());
    w(acq_pkg::WP_STEP, 8'h01);
    i_host.idle();
    ovf = 1'b1;
    r(acq_pkg::RP_CNT, 9'h100);
    r(acq_pkg::RP_MOS_STAT, mos());
    w(acq_pkg::WP_CLEAR, xs());
    r(acq_pkg::RP_MOS_STAT, mos());
    repeat (4) i_host.idle();
    `CHK(n_step - s0, 256)
    print_verdict();
  end
endmodule : acq_regs_tb
